// ---- inc/ssadc_pkg.sv ----
// shared types and constants for the single slope converter control
// assumes one clock domain and software accesses presented as one-cycle strobes
package ssadc_pkg;
	// analog control register contents
	typedef struct packed {
		logic anaIrqEn;
		logic offsetRef;
		logic swapBit;
		logic cmpBPwr;
		logic cmpAPwr;
		logic curSrcEn;
	} ssadc_actl_t;
	// timer capture control contents
	typedef struct packed {
		logic captureEnable;
		logic captureIrqEn;
		logic captureEdge;
	} ssadc_tctl_t;
	// timer status flags
	typedef struct packed {
		logic capFlag;
		logic cmpFlag;
		logic ovfFlag;
	} ssadc_tflag_t;
	// software read strobes into the timer
	typedef struct packed {
		logic rdStatus;
		logic rdCapLo;
		logic rdCmpHi;
		logic rdCmpLo;
		logic rdCntLo;
	} ssadc_trd_t;
	localparam ssadc_actl_t ACTL_RST = 6'h00;
	localparam ssadc_tctl_t TCTL_RST = 3'h0;
	localparam ssadc_tflag_t TFLAG_RST = 3'h0;
	localparam int MUX_W_DEF = 8;
	localparam int MUX_W_MAX = 16;
endpackage

// ---- verilog/ssadc_tmr_flags.sv ----
// timer flag unit: capture, compare and overflow flags with read-sequence clear
// assumes strobes are single-cycle and synchronous to sys_clk
`timescale 1ns/1ps
module ssadc_tmr_flags (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic capEvt,
	input wire logic cmpMatch,
	input wire logic ovfEvt,
	input wire ssadc_pkg::ssadc_trd_t rd,
	output ssadc_pkg::ssadc_tflag_t flags,
	output logic cmpLock
);
	typedef struct packed {
		ssadc_pkg::ssadc_tflag_t flags;
		ssadc_pkg::ssadc_tflag_t armed;
		logic lock;
	} ssadc_tf_st_t;

	ssadc_tf_st_t st_q;
	ssadc_tf_st_t st_d;
	ssadc_pkg::ssadc_tflag_t setV;
	ssadc_pkg::ssadc_tflag_t clrV;

	// flag update, set beats clear
	always_comb
	begin
		st_d = st_q;
		setV.capFlag = capEvt;
		setV.cmpFlag = cmpMatch & ~st_q.lock;
		setV.ovfFlag = ovfEvt;
		clrV.capFlag = rd.rdCapLo & st_q.armed.capFlag;
		clrV.cmpFlag = rd.rdCmpLo & st_q.armed.cmpFlag;
		clrV.ovfFlag = rd.rdCntLo & st_q.armed.ovfFlag;
		st_d.flags = (st_q.flags & ~clrV) | setV;
		// status read arms the flags then set, low-byte read disarms
		if (rd.rdStatus)
			st_d.armed = st_q.flags;
		else
			st_d.armed = st_q.armed & ~clrV;
		// high byte read locks compares until low byte read
		if (rd.rdCmpLo)
			st_d.lock = 1'b0;
		else if (rd.rdCmpHi)
			st_d.lock = 1'b1;
	end

	// state register, cleared by the asynchronous reset
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign flags = st_q.flags;
	assign cmpLock = st_q.lock;

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!arst_n);

	sequence s_status_read;
		rd.rdStatus && st_q.flags.capFlag;
	endsequence
	sequence s_low_read;
		rd.rdCapLo && !rd.rdStatus && !capEvt;
	endsequence

	a_lock_blocks: assert property (st_q.lock && !rd.rdCmpLo && !st_q.flags.cmpFlag |=> !st_q.flags.cmpFlag)
		else $error("compare flag set while high byte lock held");
	a_seq_clears: assert property (s_status_read ##1 s_low_read |=> !st_q.flags.capFlag)
		else $error("capture flag not cleared by read sequence");
	a_unarmed_keeps: assert property (st_q.flags.cmpFlag && !st_q.armed.cmpFlag && !rd.rdStatus |=> st_q.flags.cmpFlag)
		else $error("compare flag cleared without status read");
endmodule

// ---- verilog/ssadc_ctrl.sv ----
// control logic of the single slope converter analog subsystem
// assumes software accesses arrive as single-cycle strobes with data on sys_clk
`timescale 1ns/1ps
module ssadc_ctrl #(
	parameter int MUX_W = ssadc_pkg::MUX_W_DEF
) (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic maskChoiceIn,
	input wire logic timerModeEn,
	input wire logic actlWrStb,
	input wire ssadc_pkg::ssadc_actl_t actlWrData,
	input wire logic routeWrStb,
	input wire logic routeWrData,
	input wire logic tctlWrStb,
	input wire ssadc_pkg::ssadc_tctl_t tctlWrData,
	input wire logic muxWrStb,
	input wire logic [MUX_W-1:0] muxWrData,
	input wire logic flagClrStb,
	input wire ssadc_pkg::ssadc_trd_t timerRd,
	input wire logic cmpMatch,
	input wire logic ovfEvt,
	input wire logic cmpALive,
	input wire logic cmpBLive,
	output logic curSrcOn,
	output logic biasOn,
	output logic cmpAPwrOn,
	output logic cmpBPwrOn,
	output logic swapOn,
	output logic offsetRefOn,
	output logic [MUX_W-1:0] muxSwitch,
	output logic pinOut,
	output logic pinOe,
	output logic chargeOn,
	output logic cmpAFlag,
	output logic cmpBFlag,
	output logic anaIrq,
	output logic capIrq,
	output ssadc_pkg::ssadc_tflag_t timerFlags,
	output logic cmpLocked
);
	if (MUX_W < 1 || MUX_W > ssadc_pkg::MUX_W_MAX)
	begin : g_bad_width
		$error("MUX_W out of range");
	end

	typedef struct packed {
		ssadc_pkg::ssadc_actl_t actl;
		ssadc_pkg::ssadc_tctl_t tctl;
		logic route;
		logic [MUX_W-1:0] mux;
		logic optQ;
		logic optLoaded;
		logic cmpAPrev;
		logic cmpBPrev;
		logic flagA;
		logic flagB;
		logic charge;
		logic curSrc;
		logic bias;
		logic offRef;
		logic pinO;
		logic pinE;
		logic anaIrq;
		logic capIrq;
	} ssadc_st_t;

	ssadc_st_t st_q;
	ssadc_st_t st_d;
	ssadc_pkg::ssadc_tflag_t tFlags;
	logic tLock;
	logic capEdge;
	logic spurCap;
	logic capEvt;
	logic swapChange;

	// capture source: selected edge of comparator b, plus spurious set
	always_comb
	begin
		capEdge = st_q.tctl.captureEdge ? (cmpBLive & ~st_q.cmpBPrev)
			: (~cmpBLive & st_q.cmpBPrev);
		spurCap = tctlWrStb & st_q.charge & (tctlWrData != st_q.tctl);
		capEvt = (st_q.tctl.captureEnable & capEdge) | spurCap;
		swapChange = actlWrStb & (actlWrData.swapBit != st_q.actl.swapBit);
	end

	ssadc_tmr_flags u_flags (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.capEvt(capEvt),
		.cmpMatch(cmpMatch),
		.ovfEvt(ovfEvt),
		.rd(timerRd),
		.flags(tFlags),
		.cmpLock(tLock)
	);

	// next state of control registers, flags and registered outputs
	always_comb
	begin
		st_d = st_q;
		// option strap caught once after reset release
		if (!st_q.optLoaded)
		begin
			st_d.optQ = maskChoiceIn;
			st_d.optLoaded = 1'b1;
		end
		if (actlWrStb)
			st_d.actl = actlWrData;
		if (routeWrStb)
			st_d.route = routeWrData;
		if (tctlWrStb)
			st_d.tctl = tctlWrData;
		if (muxWrStb)
			st_d.mux = muxWrData;
		st_d.cmpAPrev = cmpALive;
		st_d.cmpBPrev = cmpBLive;
		// latched comparator flags, swap change may set them, set beats clear
		st_d.flagA = (st_q.flagA & ~flagClrStb) | (cmpALive & ~st_q.cmpAPrev) | swapChange;
		st_d.flagB = (st_q.flagB & ~flagClrStb) | (cmpBLive & ~st_q.cmpBPrev) | swapChange;
		// charge control: capture stops it and masks the lower flags
		if (!timerModeEn)
			st_d.charge = 1'b0;
		else if (tFlags.capFlag)
			st_d.charge = 1'b0;
		else if (tFlags.cmpFlag || tFlags.ovfFlag)
			st_d.charge = 1'b1;
		// analog enables follow the control register at once
		st_d.curSrc = st_d.actl.curSrcEn;
		st_d.bias = st_d.actl.curSrcEn | st_d.actl.cmpAPwr | st_d.actl.cmpBPwr;
		st_d.offRef = st_d.actl.offsetRef & st_d.optQ;
		// pin route has no stop gating, comparator a keeps driving
		st_d.pinE = st_d.route & st_d.optQ;
		st_d.pinO = cmpALive;
		// comparator rising edge raises the wake interrupt in any mode
		st_d.anaIrq = st_d.actl.anaIrqEn & (st_d.flagA | st_d.flagB);
		st_d.capIrq = st_d.tctl.captureIrqEn & tFlags.capFlag;
	end

	// state register, cleared by the asynchronous reset
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			st_q <= '0;
			st_q.actl <= ssadc_pkg::ACTL_RST;
			st_q.tctl <= ssadc_pkg::TCTL_RST;
		end
		else
			st_q <= st_d;
	end

	// outputs straight from state flops
	assign curSrcOn = st_q.curSrc;
	assign biasOn = st_q.bias;
	assign cmpAPwrOn = st_q.actl.cmpAPwr; // powered regardless of wait
	assign cmpBPwrOn = st_q.actl.cmpBPwr;
	assign swapOn = st_q.actl.swapBit;
	assign offsetRefOn = st_q.offRef;
	assign muxSwitch = st_q.mux;
	assign pinOut = st_q.pinO;
	assign pinOe = st_q.pinE;
	assign chargeOn = st_q.charge;
	assign cmpAFlag = st_q.flagA;
	assign cmpBFlag = st_q.flagB;
	assign anaIrq = st_q.anaIrq;
	assign capIrq = st_q.capIrq;
	assign timerFlags = tFlags;
	assign cmpLocked = tLock;

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!arst_n);

	// capture flag drops while a lower flag still waits
	sequence s_cap_cleared;
		$fell(tFlags.capFlag) && (tFlags.cmpFlag || tFlags.ovfFlag) && timerModeEn;
	endsequence

	a_mux_direct: assert property (muxWrStb |=> muxSwitch == $past(muxWrData))
		else $error("multiplexer write not applied next cycle");
	a_bias_any: assert property (actlWrStb && (actlWrData.cmpAPwr || actlWrData.cmpBPwr) |=> biasOn)
		else $error("bias off with comparator enabled");
	a_cursrc_off: assert property (actlWrStb && !actlWrData.curSrcEn |=> !curSrcOn)
		else $error("current source stayed on");
	a_option_gate: assert property (pinOe || offsetRefOn |-> st_q.optQ)
		else $error("optional function active without option");
	a_pin_follow: assert property (pinOe && $past(pinOe) |-> pinOut == $past(cmpALive))
		else $error("pin not following comparator a");
	a_capture_masks: assert property (tFlags.capFlag |=> !chargeOn)
		else $error("charge running with capture flag set");
	a_recharge_now: assert property (s_cap_cleared |=> chargeOn)
		else $error("no recharge after capture clear");
	a_spurious_cap: assert property (spurCap |=> tFlags.capFlag)
		else $error("capture control change did not set flag");
	a_wake_irq: assert property (st_q.actl.anaIrqEn && cmpALive && !st_q.cmpAPrev && !actlWrStb |=> anaIrq)
		else $error("comparator change did not raise interrupt");
	// further checks on pin route, interrupt gating and charge start
	a_route_pin: assert property (routeWrStb && routeWrData && st_q.optQ |=> pinOe)
		else $error("pin route bit did not enable the pin");
	a_irq_gated: assert property (!st_q.actl.anaIrqEn && !actlWrStb |=> !anaIrq)
		else $error("analog interrupt raised while disabled");
	a_ovf_starts: assert property (tFlags.ovfFlag && !tFlags.capFlag && timerModeEn |=> chargeOn)
		else $error("pending overflow did not start charge");
endmodule

// ---- bench/ssadc_sw_model.sv ----
// software model: register writes and timer reads as one-cycle strobes
// assumes the bench calls its tasks and the block samples on sys_clk rise
`timescale 1ns/1ps
module ssadc_sw_model (
	input wire logic sys_clk,
	output logic actlWrStb,
	output ssadc_pkg::ssadc_actl_t actlWrData,
	output logic routeWrStb,
	output logic routeWrData,
	output logic tctlWrStb,
	output ssadc_pkg::ssadc_tctl_t tctlWrData,
	output logic muxWrStb,
	output logic [7:0] muxWrData,
	output logic flagClrStb,
	output ssadc_pkg::ssadc_trd_t timerRd
);
	// all strobes idle from time zero
	initial
	begin
		{actlWrStb, actlWrData, routeWrStb, routeWrData, tctlWrStb} = '0;
		{tctlWrData, muxWrStb, muxWrData, flagClrStb, timerRd} = '0;
	end
	// one write: k picks actl, route, tctl, mux or flag clear
	task automatic wr(input int k, input logic [7:0] d);
		@(negedge sys_clk);
		case (k)
			0: {actlWrStb, actlWrData} = {1'b1, d[5:0]};
			1: {routeWrStb, routeWrData} = {1'b1, d[0]};
			2: {tctlWrStb, tctlWrData} = {1'b1, d[2:0]};
			3: {muxWrStb, muxWrData} = {1'b1, d};
			default: flagClrStb = 1'b1;
		endcase
		@(negedge sys_clk);
		{actlWrStb, routeWrStb, tctlWrStb, muxWrStb, flagClrStb} = '0;
	endtask
	// one read strobe pattern
	task automatic rd(input ssadc_pkg::ssadc_trd_t r);
		@(negedge sys_clk);
		timerRd = r;
		@(negedge sys_clk);
		timerRd = '0;
	endtask
	// status read first, then the low byte of the flag's register
	task automatic clr_seq(input ssadc_pkg::ssadc_trd_t lo);
		rd(5'h10);
		rd(lo);
	endtask
endmodule

// ---- bench/tb_top.sv ----
// self-checking bench for ssadc_ctrl with a software model
// assumes MUX_W of 8 and the package types of ssadc_pkg
`timescale 1ns/1ps
module tb_top;
	logic sysClk = 1'b0;
	logic arstN = 1'b0;
	logic maskChoiceIn = 1'b0;
	logic timerModeEn = 1'b0;
	logic cmpMatch = 1'b0;
	logic ovfEvt = 1'b0;
	logic cmpALive = 1'b0;
	logic cmpBLive = 1'b0;
	logic actlWrStb, routeWrStb, routeWrData, tctlWrStb, muxWrStb, flagClrStb;
	ssadc_pkg::ssadc_actl_t actlWrData;
	ssadc_pkg::ssadc_tctl_t tctlWrData;
	ssadc_pkg::ssadc_trd_t timerRd;
	ssadc_pkg::ssadc_tflag_t timerFlags;
	logic [7:0] muxWrData, muxSwitch;
	logic curSrcOn, biasOn, offsetRefOn, pinOut, pinOe, chargeOn, cmpAFlag, cmpBFlag, cmpLocked;
	logic cmpAPwrOn, cmpBPwrOn, swapOn, anaIrq, capIrq;
	int mismatches = 0;
	int nTests = 0;
	ssadc_sw_model ssadc_sw_model_inst (.sys_clk(sysClk), .actlWrStb, .actlWrData,
		.routeWrStb, .routeWrData, .tctlWrStb, .tctlWrData, .muxWrStb, .muxWrData,
		.flagClrStb, .timerRd);
	ssadc_ctrl #(.MUX_W(8)) ssadc_ctrl_inst (.sys_clk(sysClk), .arst_n(arstN), .maskChoiceIn,
		.timerModeEn, .actlWrStb, .actlWrData, .routeWrStb, .routeWrData, .tctlWrStb,
		.tctlWrData, .muxWrStb, .muxWrData, .flagClrStb, .timerRd, .cmpMatch, .ovfEvt,
		.cmpALive, .cmpBLive, .curSrcOn, .biasOn, .cmpAPwrOn, .cmpBPwrOn, .swapOn,
		.offsetRefOn, .muxSwitch, .pinOut, .pinOe, .chargeOn, .cmpAFlag, .cmpBFlag,
		.anaIrq, .capIrq, .timerFlags, .cmpLocked);
	// 250 MHz clock
	always #2 sysClk = ~sysClk;
	task automatic end_sim;
		if (mismatches == 0 && nTests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		nTests++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge sysClk);
	endtask
	task automatic w(input int k, input logic [7:0] d);
		ssadc_sw_model_inst.wr(k, d);
		cyc(1);
	endtask
	task automatic r(input logic [4:0] m);
		ssadc_sw_model_inst.rd(m);
	endtask
	// one-cycle event pulse: 0 compare match, 1 overflow
	task automatic evt(input int k);
		@(negedge sysClk);
		if (k == 0)
			cmpMatch = 1'b1;
		else
			ovfEvt = 1'b1;
		@(negedge sysClk);
		{cmpMatch, ovfEvt} = 2'h0;
		cyc(1);
	endtask
	task automatic do_reset(input logic strap);
		arstN = 1'b0;
		maskChoiceIn = strap;
		cyc(16);
		arstN = 1'b1;
		cyc(2);
	endtask
	task automatic t_power;
		for (int i = 0; i < 3; i++)
		begin
			w(0, 8'h01 << i);
			chk(8'({biasOn, curSrcOn}), (i == 0) ? 8'h03 : 8'h02);
			chk(8'({cmpBPwrOn, cmpAPwrOn, curSrcOn}), 8'h01 << i);
		end
		w(0, 8'h00);
		chk(8'({biasOn, curSrcOn}), 8'h00);
		w(0, 8'h10);
		w(1, 8'h01);
		chk(8'({offsetRefOn, pinOe}), 8'h00);
	endtask
	task automatic t_option;
		do_reset(1'b1);
		w(0, 8'h10);
		w(1, 8'h01);
		chk(8'({offsetRefOn, pinOe, pinOut}), 8'h06);
		cmpALive = 1'b1;
		cyc(2);
		chk(8'(pinOut), 8'h01);
	endtask
	task automatic t_mux_swap;
		w(3, 8'hA5);
		chk(muxSwitch, 8'hA5);
		w(3, 8'h5A);
		chk(muxSwitch, 8'h5A);
		w(3, 8'h1A); // hold switch dropped in a write of its own
		chk(muxSwitch, 8'h1A);
		w(3, 8'h19); // channel change only after that
		chk(muxSwitch, 8'h19);
		w(4, 8'h00);
		w(0, 8'h08);
		chk(8'({swapOn, cmpAFlag, cmpBFlag}), 8'h07);
		w(4, 8'h00);
		chk(8'({cmpAFlag, cmpBFlag}), 8'h00);
	endtask
	task automatic t_lock;
		r(5'h04);
		evt(0);
		chk(8'({cmpLocked, timerFlags}), 8'h08);
		r(5'h02);
		evt(0);
		r(5'h02);
		chk(8'({cmpLocked, timerFlags}), 8'h02);
		ssadc_sw_model_inst.clr_seq(5'h02);
		cyc(1);
		chk(8'(timerFlags), 8'h00);
	endtask
	task automatic t_charge;
		timerModeEn = 1'b1;
		w(2, 8'h05);
		evt(1);
		chk(8'(chargeOn), 8'h01);
		cmpBLive = 1'b1; // held far longer than one sample
		cyc(3);
		chk(8'({timerFlags, chargeOn}), 8'h0A);
		ssadc_sw_model_inst.clr_seq(5'h08);
		cyc(2);
		chk(8'({timerFlags, chargeOn}), 8'h03);
		w(2, 8'h04);
		cyc(1);
		chk(8'({timerFlags, chargeOn}), 8'h0A);
		w(2, 8'h06); // capture irq alone, analog irq stays off
		chk(8'({capIrq, timerFlags, chargeOn}), 8'h1A);
	endtask
	task automatic t_wake;
		timerModeEn = 1'b0;
		w(2, 8'h00); // capture irq off before analog irq on
		w(4, 8'h00);
		w(0, 8'h2A); // swap kept as it stood for the held sample
		chk(8'({anaIrq, capIrq, swapOn, cmpAPwrOn, cmpBPwrOn}), 8'h06);
		cmpALive = 1'b0;
		cyc(2); // low for longer than one sample
		cmpALive = 1'b1;
		cyc(1); // first poll at half the loop time
		chk(8'({anaIrq, cmpAFlag, cmpBFlag}), 8'h06);
		cyc(2); // later polls once per full loop
		chk(8'({anaIrq, cmpAFlag, cmpBFlag}), 8'h06);
		w(4, 8'h00);
		chk(8'({anaIrq, cmpAFlag, cmpBFlag}), 8'h00);
	endtask
	// watchdog well beyond the expected run
	initial
	begin
		#20000;
		mismatches++;
		end_sim();
	end
	// main sequence
	initial
	begin
		do_reset(1'b0);
		t_power();
		t_option();
		t_mux_swap();
		t_lock();
		t_charge();
		t_wake();
		end_sim();
	end
endmodule
